// ===== src/ipw_defs.svh
// Purpose: constants of the indexed-port watchdog
// Assumes: 20 MHz mclk_i
// Notes: offsets, fields, resets and timing counts
`ifndef IPW_DEFS_SVH
`define IPW_DEFS_SVH
// ---------------------------------------------------------------
// port addresses and index values
// ---------------------------------------------------------------
`define IPW_PORT_INDEX 1'h0
`define IPW_PORT_DATA 1'h1
`define IPW_UNLOCK_VAL 8'h87
`define IPW_LOCK_VAL 8'hAA
`define IPW_WDT_BANK 8'h08
// ---------------------------------------------------------------
// register indices
// ---------------------------------------------------------------
`define IPW_IDX_BANK 8'h07
`define IPW_IDX_ACT 8'h30
`define IPW_IDX_UNIT 8'hF5
`define IPW_IDX_COUNT 8'hF6
`define IPW_IDX_CTRL 8'hF7
// ---------------------------------------------------------------
// fields and reset values
// ---------------------------------------------------------------
`define IPW_ACT_ON 8'h01
`define IPW_UNIT_MIN_BIT 3
`define IPW_UNIT_FAST_BIT 4
`define IPW_CTRL_MOUSE_BIT 7
`define IPW_CTRL_KBD_BIT 6
`define IPW_CTRL_FORCE_BIT 5
`define IPW_CTRL_STAT_BIT 4
`define IPW_RST_BYTE 8'h00
// ---------------------------------------------------------------
// timing: one millisecond base tick
// ---------------------------------------------------------------
`define IPW_CLK_HZ 20000000
`define IPW_MS_PER_S 1000
`define IPW_CYC_PER_MS (`IPW_CLK_HZ / `IPW_MS_PER_S)
`define IPW_MS_PER_SEC 1000
`define IPW_SEC_PER_MIN 60
// ---------------------------------------------------------------
// host command port registers (own map)
// ---------------------------------------------------------------
`define IPW_H_CMD 4'h0
`define IPW_H_WDATA 4'h1
`define IPW_H_RDATA 4'h2
`define IPW_H_STAT 4'h3
`define IPW_H_IRQ_STAT 4'h4
`define IPW_H_IRQ_CLR 4'h5
`define IPW_H_IRQ_EN 4'h6
`define IPW_CMD_WR 2'h1
`define IPW_CMD_RD 2'h2
`endif

// ===== src/ipw_pkg.sv
// Purpose: types of the indexed-port watchdog
// Assumes: nothing
// Notes: state of the unlock sequence
package ipw_pkg;
  typedef enum logic [1:0] {
    IPW_LOCKED = 2'h0,
    IPW_HALF = 2'h1,
    IPW_OPEN = 2'h3
  } ipw_cfg_t;
endpackage

// ===== src/ipw_if.sv
// Purpose: index/data i/o port between host and watchdog
// Assumes: single clock, one-cycle strobes
// Notes: read data valid the cycle after rd
`timescale 1ns/1ps
`default_nettype none
interface ipw_if;
  logic addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  modport dev (input addr, input wdata, input wr, input rd,
    output rdata);
  modport host (output addr, output wdata, output wr, output rd,
    input rdata);
endinterface
`default_nettype wire

// ===== src/ipw_device.sv
// Purpose: watchdog reached through an index/data port pair
// Assumes: kbd/mouse activity pins are asynchronous levels
// Notes: bank 08 must be selected before watchdog indices work
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "ipw_defs.svh"
module ipw_device
  import ipw_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  ipw_if.dev port,
  input wire logic kbd_act_i,
  input wire logic mouse_act_i,
  output logic timeout_o
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  ipw_cfg_t cfg_reg, cfg_next;
  logic [7:0] index_reg, bank_reg, act_reg, unit_reg, count_reg;
  logic [7:0] ctrl_reg, rdata_reg, left_reg;
  logic stat_reg;
  logic [14:0] ms_div_reg;
  logic [9:0] ms_cnt_reg;
  logic [5:0] sec_cnt_reg;
  logic [5:0] fm_cnt_reg;
  logic [2:0] kbd_sync_reg, mouse_sync_reg;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire logic idx_wr = port.wr && (port.addr == `IPW_PORT_INDEX);
  wire logic dat_wr = port.wr && (port.addr == `IPW_PORT_DATA);
  wire logic dat_rd = port.rd && (port.addr == `IPW_PORT_DATA);
  wire logic open_cfg = (cfg_reg == IPW_OPEN);
  wire logic wdt_bank = (bank_reg == `IPW_WDT_BANK);
  // bank select itself is global, the rest needs bank 08
  wire logic wr_bank = open_cfg && dat_wr
    && index_reg == `IPW_IDX_BANK;
  wire logic wr_wdt = open_cfg && dat_wr && wdt_bank;
  wire logic wr_act = wr_wdt && index_reg == `IPW_IDX_ACT;
  wire logic wr_unit = wr_wdt && index_reg == `IPW_IDX_UNIT;
  wire logic wr_count = wr_wdt && index_reg == `IPW_IDX_COUNT;
  wire logic wr_ctrl = wr_wdt && index_reg == `IPW_IDX_CTRL;
  wire logic active = (act_reg == `IPW_ACT_ON);
  wire logic fast = unit_reg[`IPW_UNIT_FAST_BIT];
  wire logic minutes = unit_reg[`IPW_UNIT_MIN_BIT];

  // ---------------------------------------------------------------
  // unlock sequencer
  // ---------------------------------------------------------------
  // any other index write between the two 87s restarts the sequence
  always_comb begin
    cfg_next = cfg_reg;
    if (idx_wr) begin
      case (cfg_reg)
        IPW_LOCKED: cfg_next = (port.wdata == `IPW_UNLOCK_VAL) ?
          IPW_HALF : IPW_LOCKED;
        IPW_HALF: cfg_next = (port.wdata == `IPW_UNLOCK_VAL) ?
          IPW_OPEN : IPW_LOCKED;
        IPW_OPEN: cfg_next = (port.wdata == `IPW_LOCK_VAL) ?
          IPW_LOCKED : IPW_OPEN;
        default: cfg_next = IPW_LOCKED;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      cfg_reg <= IPW_LOCKED;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // index latch: only while open, so 87 is not taken as an index
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      index_reg <= `IPW_RST_BYTE;
    end else if (idx_wr && open_cfg) begin
      index_reg <= port.wdata;
    end
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      bank_reg <= `IPW_RST_BYTE;
      act_reg <= `IPW_RST_BYTE;
      unit_reg <= `IPW_RST_BYTE;
      count_reg <= `IPW_RST_BYTE;
    end else begin
      if (wr_bank) begin
        bank_reg <= port.wdata;
      end
      if (wr_act) begin
        act_reg <= port.wdata;
      end
      if (wr_unit) begin
        unit_reg <= port.wdata;
      end
      if (wr_count) begin
        count_reg <= port.wdata;
      end
    end
  end

  // force bit is never stored; it only makes a one-cycle event
  wire logic force_ev = wr_ctrl && port.wdata[`IPW_CTRL_FORCE_BIT];
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ctrl_reg <= `IPW_RST_BYTE;
    end else if (wr_ctrl) begin
      ctrl_reg <= {port.wdata[7:6], 6'h00};
    end
  end

  // ---------------------------------------------------------------
  // read path, one cycle after the strobe
  // ---------------------------------------------------------------
  wire logic [7:0] ctrl_rd = {ctrl_reg[7:6], 1'b0, stat_reg, 4'h0};
  wire logic rd_ok = open_cfg && dat_rd && wdt_bank;
  wire logic [7:0] rd_mux =
    !rd_ok ? 8'h00 :
    (index_reg == `IPW_IDX_CTRL) ? ctrl_rd :
    (index_reg == `IPW_IDX_COUNT) ? count_reg :
    (index_reg == `IPW_IDX_UNIT) ? unit_reg :
    (index_reg == `IPW_IDX_ACT) ? act_reg : 8'h00;
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rdata_reg <= `IPW_RST_BYTE;
    end else begin
      rdata_reg <= rd_mux;
    end
  end
  assign port.rdata = rdata_reg;

  // ---------------------------------------------------------------
  // activity synchronisers and edge detect
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      kbd_sync_reg <= 3'h0;
      mouse_sync_reg <= 3'h0;
    end else begin
      kbd_sync_reg <= {kbd_sync_reg[1:0], kbd_act_i};
      mouse_sync_reg <= {mouse_sync_reg[1:0], mouse_act_i};
    end
  end
  wire logic kbd_ev = kbd_sync_reg[1] && !kbd_sync_reg[2];
  wire logic mouse_ev = mouse_sync_reg[1] && !mouse_sync_reg[2];
  wire logic kick =
    (kbd_ev && ctrl_reg[`IPW_CTRL_KBD_BIT]) ||
    (mouse_ev && ctrl_reg[`IPW_CTRL_MOUSE_BIT]);

  // ---------------------------------------------------------------
  // time base: ms tick, second tick, minute tick
  // ---------------------------------------------------------------
  wire logic ms_tick = (ms_div_reg == 15'(`IPW_CYC_PER_MS - 1));
  wire logic sec_tick = ms_tick &&
    (ms_cnt_reg == 10'(`IPW_MS_PER_SEC - 1));
  wire logic min_tick = sec_tick &&
    (sec_cnt_reg == 6'(`IPW_SEC_PER_MIN - 1));
  // fast minutes: sixty ms make a thousandth of a minute
  wire logic fm_tick = ms_tick &&
    (fm_cnt_reg == 6'(`IPW_SEC_PER_MIN - 1));
  // fast mode: a ms per count, or 60 ms per count in minutes
  wire logic unit_tick = fast ? (minutes ? fm_tick : ms_tick)
    : (minutes ? min_tick : sec_tick);
  // prescaler restarts on reload so the first unit is whole
  wire logic reload = wr_count || kick;
  always_ff @(posedge mclk_i) begin
    if (reset_i || reload) begin
      ms_div_reg <= 15'h0000;
      ms_cnt_reg <= 10'h000;
      sec_cnt_reg <= 6'h00;
      fm_cnt_reg <= 6'h00;
    end else begin
      ms_div_reg <= ms_tick ? 15'h0000 : ms_div_reg + 15'h0001;
      if (ms_tick) begin
        ms_cnt_reg <= sec_tick ? 10'h000 : ms_cnt_reg + 10'h001;
        fm_cnt_reg <= fm_tick ? 6'h00 : fm_cnt_reg + 6'h01;
      end
      if (sec_tick) begin
        sec_cnt_reg <= min_tick ? 6'h00 : sec_cnt_reg + 6'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // down counter and timeout
  // ---------------------------------------------------------------
  wire logic expire = active && unit_tick && (left_reg == 8'h01);
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      left_reg <= `IPW_RST_BYTE;
    end else if (wr_count) begin
      left_reg <= port.wdata;
    end else if (kick) begin
      left_reg <= count_reg;
    end else if (active && unit_tick && left_reg != 8'h00) begin
      left_reg <= left_reg - 8'h01;
    end
  end

  // zero count stops the timer; force still works at zero
  // event wins over a same-cycle count write
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      stat_reg <= 1'b0;
    end else if (expire || force_ev) begin
      stat_reg <= 1'b1;
    end else if (wr_count) begin
      stat_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      timeout_o <= 1'b0;
    end else begin
      timeout_o <= stat_reg;
    end
  end
endmodule
`default_nettype wire

// ===== src/ipw_host.sv
// Purpose: host end driving the index/data port
// Assumes: software issues one command at a time
// Notes: commands taken only while idle
`timescale 1ns/1ps
`default_nettype none
`include "ipw_defs.svh"
module ipw_host
  import ipw_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [3:0] sw_addr_i,
  input wire logic [7:0] sw_wdata_i,
  input wire logic sw_wr_i,
  input wire logic sw_rd_i,
  output logic [7:0] sw_rdata_o,
  output logic irq_o,
  ipw_if.host port
);
  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  logic [7:0] wdata_reg, rdata_reg, sw_rdata_reg;
  logic port_addr_reg, busy_reg, rd_wait_reg;
  logic wr_reg, rd_reg;
  logic [1:0] irq_stat_reg, irq_en_reg;
  logic irq_reg;

  // command word: bits 1:0 kind, bit 2 port (0 index, 1 data)
  wire logic sw_cmd = sw_wr_i && sw_addr_i == `IPW_H_CMD && !busy_reg;
  wire logic cmd_wr = sw_cmd && sw_wdata_i[1:0] == `IPW_CMD_WR;
  wire logic cmd_rd = sw_cmd && sw_wdata_i[1:0] == `IPW_CMD_RD;
  wire logic ev_wr_done = wr_reg;
  wire logic ev_rd_done = rd_wait_reg;

  // one port cycle per command; busy until the write strobe is out or read data returns
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      rd_wait_reg <= 1'b0;
      busy_reg <= 1'b0;
      port_addr_reg <= 1'b0;
      wdata_reg <= 8'h00;
      rdata_reg <= 8'h00;
    end else begin
      wr_reg <= cmd_wr;
      rd_reg <= cmd_rd;
      rd_wait_reg <= rd_reg;
      busy_reg <= cmd_wr || cmd_rd || (busy_reg && !ev_rd_done
        && !ev_wr_done);
      if (sw_cmd) begin
        port_addr_reg <= sw_wdata_i[2];
      end
      if (sw_wr_i && sw_addr_i == `IPW_H_WDATA) begin
        wdata_reg <= sw_wdata_i;
      end
      if (rd_wait_reg) begin
        rdata_reg <= port.rdata;
      end
    end
  end

  assign port.addr = port_addr_reg;
  assign port.wdata = wdata_reg;
  assign port.wr = wr_reg;
  assign port.rd = rd_reg;

  // ---------------------------------------------------------------
  // interrupts: bit0 write done, bit1 read done
  // ---------------------------------------------------------------
  wire logic [1:0] ev = {ev_rd_done, ev_wr_done};
  wire logic clr_hit = sw_wr_i && sw_addr_i == `IPW_H_IRQ_CLR;
  wire logic [1:0] clr = clr_hit ? sw_wdata_i[1:0] : 2'h0;
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      irq_stat_reg <= 2'h0;
      irq_en_reg <= 2'h0;
      irq_reg <= 1'b0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~clr) | ev; // set wins
      if (sw_wr_i && sw_addr_i == `IPW_H_IRQ_EN) begin
        irq_en_reg <= sw_wdata_i[1:0];
      end
      irq_reg <= |(((irq_stat_reg & ~clr) | ev) & irq_en_reg);
    end
  end
  assign irq_o = irq_reg;

  // ---------------------------------------------------------------
  // software read port
  // ---------------------------------------------------------------
  wire logic [7:0] sw_mux =
    (sw_addr_i == `IPW_H_RDATA) ? rdata_reg :
    (sw_addr_i == `IPW_H_WDATA) ? wdata_reg :
    (sw_addr_i == `IPW_H_STAT) ? {7'h00, busy_reg} :
    (sw_addr_i == `IPW_H_IRQ_STAT) ? {6'h00, irq_stat_reg} :
    (sw_addr_i == `IPW_H_IRQ_EN) ? {6'h00, irq_en_reg} : 8'h00;
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      sw_rdata_reg <= 8'h00;
    end else begin
      sw_rdata_reg <= sw_rd_i ? sw_mux : 8'h00;
    end
  end
  assign sw_rdata_o = sw_rdata_reg;
endmodule
`default_nettype wire

// ===== tb/ipw_sva.sv
// Purpose: port and timeout checks of the index/data watchdog
// Assumes: one clock, sync active-high reset
// Notes: shadows unlock, index and bank to judge gated accesses
`timescale 1ns/1ps
`default_nettype none
`include "ipw_defs.svh"
module ipw_sva (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic timeout_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  // ----------------------------------------------------------
  // shadow state
  // ----------------------------------------------------------
  logic half_reg;
  logic open_reg;
  logic [7:0] idx_reg;
  logic [7:0] bank_reg;
  logic [7:0] act_reg;
  logic [7:0] cnt_reg;
  // decode of gated data writes
  wire logic iw = wr && !addr;
  wire logic gate = open_reg && (idx_reg == `IPW_IDX_BANK ||
    bank_reg == `IPW_WDT_BANK);
  wire logic dw = wr && addr && gate;
  wire logic cnt_wr = dw && idx_reg == `IPW_IDX_COUNT;
  wire logic frc_wr = dw && idx_reg == `IPW_IDX_CTRL && wdata[5];
  // index only latched while open, so a locked write cannot move it
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      half_reg <= 1'h0;
      open_reg <= 1'h0;
      idx_reg <= 8'h00;
      bank_reg <= 8'h00;
      act_reg <= 8'h00;
      cnt_reg <= 8'h00;
    end else if (iw && open_reg) begin
      open_reg <= wdata != `IPW_LOCK_VAL;
      idx_reg <= wdata;
    end else if (iw) begin
      half_reg <= wdata == `IPW_UNLOCK_VAL && !half_reg;
      open_reg <= wdata == `IPW_UNLOCK_VAL && half_reg;
    end else if (dw) begin
      if (idx_reg == `IPW_IDX_BANK) bank_reg <= wdata;
      if (idx_reg == `IPW_IDX_ACT) act_reg <= wdata;
      if (cnt_wr) cnt_reg <= wdata;
    end
  end
  sequence force_s;
    frc_wr ##1 !cnt_wr;
  endsequence
  // ----------------------------------------------------------
  // assertions
  // ----------------------------------------------------------
  strobe_excl_a: assert property (!(wr && rd))
    else $error("read and write strobes together");
  rdata_idle_a: assert property (
    !$past(rd) |-> rdata == 8'h00)
    else $error("read data outside its cycle");
  locked_read_a: assert property (
    rd && addr && !open_reg |=> rdata == 8'h00)
    else $error("data read while locked");
  bank_gate_a: assert property (
    rd && addr && open_reg && !gate |=> rdata == 8'h00)
    else $error("data read outside the watchdog bank");
  force_out_a: assert property (force_s |-> ##1 timeout_o)
    else $error("forced timeout missing");
  count_clear_a: assert property (cnt_wr |-> ##2 !timeout_o)
    else $error("count write left timeout set");
  timeout_hold_a: assert property (
    timeout_o && !cnt_wr && !$past(cnt_wr) |=> timeout_o)
    else $error("timeout dropped without count write");
  timeout_cause_a: assert property (
    $rose(timeout_o) |-> $past(frc_wr, 2) ||
    (act_reg == `IPW_ACT_ON && cnt_reg != 8'h00))
    else $error("timeout with no cause");
endmodule
`default_nettype wire

// ===== tb/indexed_port_watchdog_timer_bench.sv
// Purpose: self-checking bench, host end driving the device end
// Assumes: 20 MHz clock, fast mode gives a 1 ms count
// Notes: seconds and minutes modes are too long to run
`timescale 1ns/1ps
`default_nettype none
`include "ipw_defs.svh"
module indexed_port_watchdog_timer_bench;
  logic mclk_i;
  logic reset_i;
  logic sw_wr_i;
  logic sw_rd_i;
  logic kbd_act_i;
  logic mouse_act_i;
  logic [3:0] sw_addr_i;
  logic [7:0] sw_wdata_i;
  logic [7:0] sw_rdata_o;
  logic [7:0] got;
  logic irq_o;
  logic timeout_o;
  int err_count;
  int tests_run;
  // rows: kind (0 index wr, 1 data wr, 3 data rd), data, expected
  logic [17:0] rows [18] = '{
    {2'h0, 8'hF7, 8'h00}, {2'h1, 8'h20, 8'h00}, {2'h3, 8'h00, 8'h00},
    {2'h0, 8'h87, 8'h00}, {2'h0, 8'h87, 8'h00}, {2'h0, 8'hF7, 8'h00},
    {2'h1, 8'h20, 8'h00}, {2'h3, 8'h00, 8'h00}, {2'h0, 8'h07, 8'h00},
    {2'h1, 8'h08, 8'h00}, {2'h0, 8'hF7, 8'h00}, {2'h1, 8'h20, 8'h01},
    {2'h3, 8'h00, 8'h10}, {2'h0, 8'hF6, 8'h01}, {2'h1, 8'h00, 8'h00},
    {2'h0, 8'hAA, 8'h00}, {2'h1, 8'h20, 8'h00}, {2'h3, 8'h00, 8'h00}};
  ipw_if bus ();
  ipw_device u_ipw_device (.mclk_i(mclk_i), .reset_i(reset_i),
    .port(bus.dev), .kbd_act_i(kbd_act_i), .mouse_act_i(mouse_act_i),
    .timeout_o(timeout_o));
  ipw_host u_ipw_host (.mclk_i(mclk_i), .reset_i(reset_i),
    .sw_addr_i(sw_addr_i), .sw_wdata_i(sw_wdata_i), .sw_wr_i(sw_wr_i),
    .sw_rd_i(sw_rd_i), .sw_rdata_o(sw_rdata_o), .irq_o(irq_o),
    .port(bus.host));
  ipw_sva u_ipw_sva (.mclk_i(mclk_i), .reset_i(reset_i), .addr(bus.addr),
    .wdata(bus.wdata), .wr(bus.wr), .rd(bus.rd), .rdata(bus.rdata),
    .timeout_o(timeout_o));
  // ----------------------------------------------------------
  // tasks
  // ----------------------------------------------------------
  initial begin
    mclk_i = 1'h0;
    forever #25 mclk_i = ~mclk_i;
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic sw_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    sw_addr_i <= a;
    sw_wdata_i <= d;
    sw_wr_i <= 1'h1;
    @(posedge mclk_i);
    sw_wr_i <= 1'h0;
  endtask
  task automatic sw_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    sw_addr_i <= a;
    sw_rd_i <= 1'h1;
    @(posedge mclk_i);
    sw_rd_i <= 1'h0;
    @(negedge mclk_i);
    d = sw_rdata_o;
  endtask
  // one port cycle; polls busy since a command is lost while busy
  task automatic op(input logic [1:0] k, input logic p, input logic [7:0] d);
    logic [7:0] s;
    int n;
    sw_wr(`IPW_H_WDATA, d);
    sw_wr(`IPW_H_CMD, {5'h00, p, k});
    n = 0;
    do begin
      sw_rd(`IPW_H_STAT, s);
      n++;
    end while (s[0] !== 1'h0 && n < 20);
    if (s[0] !== 1'h0) begin
      err_count++;
      $display("Error at %0t: busy %h polls %h", $time, s, n);
      end_of_test();
    end
  endtask
  task automatic wr2(input logic [7:0] i, input logic [7:0] d);
    op(`IPW_CMD_WR, 1'h0, i);
    op(`IPW_CMD_WR, 1'h1, d);
  endtask
  task automatic wait_to(input int lo, input int hi);
    int n;
    n = 0;
    while (timeout_o !== 1'h1 && n < hi) begin
      @(negedge mclk_i);
      n++;
    end
    tests_run++;
    if (timeout_o !== 1'h1 || n < lo) begin
      err_count++;
      $display("Error at %0t: waited %h cycles, from %h", $time, n, lo);
      end_of_test();
    end
  endtask
  task automatic pulse(input logic m);
    if (m) mouse_act_i <= 1'h1;
    else kbd_act_i <= 1'h1;
    repeat (4) @(posedge mclk_i);
    mouse_act_i <= 1'h0;
    kbd_act_i <= 1'h0;
  endtask
  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    err_count = 0;
    tests_run = 0;
    reset_i = 1'h1;
    sw_addr_i = 4'h0;
    sw_wdata_i = 8'h00;
    sw_wr_i = 1'h0;
    sw_rd_i = 1'h0;
    kbd_act_i = 1'h0;
    mouse_act_i = 1'h0;
    repeat (16) @(posedge mclk_i);
    reset_i <= 1'h0;
    @(negedge mclk_i);
    chk({6'h00, irq_o, timeout_o}, 8'h00);
    for (int i = 0; i < 18; i++) begin
      if (rows[i][17]) begin
        op(`IPW_CMD_RD, 1'h1, 8'h00);
        sw_rd(`IPW_H_RDATA, got);
      end else begin
        op(`IPW_CMD_WR, rows[i][16], rows[i][15:8]);
        got = {7'h00, timeout_o};
      end
      chk(got, rows[i][7:0]);
    end
    $display("test table done");
    op(`IPW_CMD_WR, 1'h0, `IPW_UNLOCK_VAL);
    op(`IPW_CMD_WR, 1'h0, `IPW_UNLOCK_VAL);
    wr2(`IPW_IDX_BANK, `IPW_WDT_BANK);
    wr2(`IPW_IDX_ACT, `IPW_ACT_ON);
    wr2(`IPW_IDX_UNIT, 8'h10);
    wr2(`IPW_IDX_COUNT, 8'h01);
    wait_to(19900, 20100);
    $display("test expiry done");
    // keyboard then mouse each push expiry past the 20000 mark
    wr2(`IPW_IDX_CTRL, 8'hC0);
    wr2(`IPW_IDX_COUNT, 8'h01);
    repeat (8000) @(posedge mclk_i);
    pulse(1'h0);
    repeat (8000) @(posedge mclk_i);
    pulse(1'h1);
    repeat (14000) @(posedge mclk_i);
    @(negedge mclk_i);
    chk({7'h00, timeout_o}, 8'h00);
    wait_to(4000, 8000);
    $display("test reload done");
    wr2(`IPW_IDX_ACT, 8'h00);
    wr2(`IPW_IDX_COUNT, 8'h01);
    repeat (21000) @(posedge mclk_i);
    @(negedge mclk_i);
    chk({7'h00, timeout_o}, 8'h00);
    $display("test inactive done");
    // host interrupt: raise, clear, mask
    sw_wr(`IPW_H_IRQ_CLR, 8'h03);
    sw_wr(`IPW_H_IRQ_EN, 8'h01);
    op(`IPW_CMD_WR, 1'h0, `IPW_LOCK_VAL);
    chk({7'h00, irq_o}, 8'h01);
    sw_wr(`IPW_H_IRQ_CLR, 8'h01);
    sw_rd(`IPW_H_IRQ_STAT, got);
    chk({got[0], irq_o}, 2'h0);
    sw_wr(`IPW_H_IRQ_EN, 8'h00);
    op(`IPW_CMD_WR, 1'h0, 8'h00);
    sw_rd(`IPW_H_IRQ_STAT, got);
    chk({got[0], irq_o}, 2'h2);
    // a port read sets the read-done bit beside the write-done bit
    op(`IPW_CMD_RD, 1'h1, 8'h00);
    sw_rd(`IPW_H_IRQ_STAT, got);
    chk({got[1:0], irq_o}, 3'h6);
    sw_rd(4'hF, got);
    chk(got, 8'h00);
    $display("test interrupt done");
    end_of_test();
  end
endmodule
`default_nettype wire
